// [tmc_checker.sv]
// Port checker of the tone and melody control block.
// Assumes it is bound to tmc_top, one clock domain.
`timescale 1ns/100ps
`default_nettype none
module tmc_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        port_ff_wr,
   input wire logic        port_ff_wdata,
   input wire logic        port_ff_rd,
   input wire logic        pin_level_rd,
   input wire logic        shared_melody_pin_i,
   input wire logic        tone_oe,
   input wire logic        hg_synth_run,
   input wire logic        lg_synth_run,
   input wire logic        hg_synth_tick,
   input wire logic [7:0]  port0_irq_req,
   input wire logic [7:0]  port0_irq_en,
   input wire logic [7:0]  port0_irq_out
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
      else $error("write not answered");
   a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
      else $error("read not answered");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_pair_equal: assert property ((port0_irq_en & 8'h55)
      == ((port0_irq_en >> 1) & 8'h55))
      else $error("pair enables differ");
   a_irq_gated: assert property
      (1'b1 |=> (port0_irq_out & ~$past(port0_irq_req)) == 8'h00)
      else $error("interrupt without request");
   // Tone enable and run flags update on the same edge
   a_tone_needs_run: assert property
      (tone_oe |-> (hg_synth_run || lg_synth_run))
      else $error("tone driven while idle");
   a_tick_pulse: assert property (hg_synth_tick |=> !hg_synth_tick)
      else $error("tick too long");
   a_port_ff_follow: assert property (port_ff_wr
      |-> ##2 port_ff_rd == $past(port_ff_wdata, 2))
      else $error("port flip-flop not written");
   a_level_follow: assert property
      (1'b1 |=> pin_level_rd == $past(shared_melody_pin_i))
      else $error("pin level not read");
endmodule
bind tmc_top tmc_checker chk (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .s_axi_rdata, .port_ff_wr, .port_ff_wdata, .port_ff_rd, .pin_level_rd,
   .shared_melody_pin_i, .tone_oe, .hg_synth_run, .lg_synth_run,
   .hg_synth_tick, .port0_irq_req, .port0_irq_en, .port0_irq_out);
`default_nettype wire

// [tmc_pin_load.sv]
// Load on the shared melody pin.
// Assumes enable and data come from tmc_top.
`timescale 1ns/100ps
`default_nettype none
module tmc_pin_load (
   input  wire logic pin_o,
   input  wire logic pin_oe,
   output wire logic pin_i
);
   // Released quasi-bidirectional line is pulled up
   assign pin_i = pin_oe ? pin_o : 1'b1;
endmodule
`default_nettype wire

// [tmc_regs.vh]
// Constants of the tone and melody control block.
// Assumes the includer works in plain Verilog-2005.
`ifndef TMC_REGS_VH
`define TMC_REGS_VH

// Register indices; byte address is four times these
`define TMC_IDX_HGD      6'h11
`define TMC_IDX_LGD      6'h12
`define TMC_IDX_CTL      6'h13

// Control register fields
`define TMC_CTL_MEL_BIT  0
`define TMC_CTL_EN_LSB   4
`define TMC_CTL_EN_MSB   7
`define TMC_CTL_WMASK    8'hF1
`define TMC_CTL_RESET    8'h00

// Reset values
`define TMC_DIV_RESET    8'h00
`define TMC_PORT_RESET   1'b1

// Divider timing: period = MUL * (x + OFS) clocks
`define TMC_DIV_MUL      23
`define TMC_DIV_OFS      2

// AXI responses
`define TMC_RESP_OKAY    2'b00
`define TMC_RESP_SLVERR  2'b10

`endif

// [tmc_testbench.sv]
// Self-checking bench of the tone and melody control block.
// Assumes tmc_top, tmc_pin_load and the bound checker.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
   $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
module testbench;
   localparam logic [1:0] OK = 2'h0, ER = 2'h2;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [7:0]  port0_irq_req = 8'h00, port0_irq_en, port0_irq_out;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, port_ff_wr = 1'b0, port_ff_wdata = 1'b0;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, port_ff_rd, pin_level_rd, shared_melody_pin_i;
   logic        shared_melody_pin_o, shared_melody_pin_oe, tone_oe;
   logic        gen_power_on, hg_synth_run, lg_synth_run;
   logic        hg_synth_tick, lg_synth_tick;
   int          fails = 0, compares = 0;
   always #20 aclk = ~aclk;
   tmc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .port_ff_wr, .port_ff_wdata, .port_ff_rd,
      .pin_level_rd, .shared_melody_pin_i, .shared_melody_pin_o,
      .shared_melody_pin_oe, .tone_oe, .gen_power_on, .hg_synth_run,
      .lg_synth_run, .hg_synth_tick, .lg_synth_tick, .port0_irq_req,
      .port0_irq_en, .port0_irq_out);
   tmc_pin_load load (.pin_o(shared_melody_pin_o),
      .pin_oe(shared_melody_pin_oe), .pin_i(shared_melody_pin_i));
   task automatic conclude;
      $display("fails=%0d compares=%0d", fails, compares);
      if (fails == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic tmo;
      fails++;
      $display("unexpected at %0t: timeout", $time);
      conclude();
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, d, input logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      if (n == 20) tmo();
      s_axi_bready <= 1'b0;
      `CHK(s_axi_bresp, r)
   endtask
   task automatic rd(input logic [7:0] a, d, input logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      // Late rready makes the slave hold its answer once
      for (n = 0; n < 20; n++) begin
         @(posedge aclk);
         if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) break;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         else s_axi_rready <= 1'b1;
      end
      if (n == 20) tmo();
      s_axi_rready <= 1'b0;
      `CHK(s_axi_rdata, {24'h0, d})
      `CHK(s_axi_rresp, r)
   endtask
   task automatic ffw(input logic v);
      @(posedge aclk);
      port_ff_wr <= 1'b1;
      port_ff_wdata <= v;
      @(posedge aclk);
      port_ff_wr <= 1'b0;
      cyc(3);
   endtask
   task automatic wt(input logic hi, output int p);
      p = 0;
      do begin
         @(posedge aclk);
         p++;
      end while ((hi ? hg_synth_tick : lg_synth_tick) !== 1'b1 && p < 3000);
      if (p >= 3000) tmo();
   endtask
   task automatic per(input logic hi, input int x);
      int p;
      wt(hi, p);
      wt(hi, p);
      `CHK(p, 23 * (x + 2))
   endtask
   task automatic t_regs;
      rd(8'h4C, 8'h00, OK);
      rd(8'h44, 8'h00, OK);
      wr(8'h4C, 8'hFF, OK);
      rd(8'h4C, 8'hF1, OK);
      wr(8'h48, 8'h5A, OK);
      rd(8'h48, 8'h00, OK);
      wr(8'h48, 8'h00, OK);
      wr(8'h50, 8'h0E, ER);
      wr(8'h4D, 8'h00, ER);
      rd(8'h50, 8'h00, ER);
      rd(8'h4C, 8'hF1, OK);
      $display("regs test done");
   endtask
   task automatic t_irq;
      int n;
      port0_irq_req <= 8'hFF;
      for (n = 0; n < 4; n++) begin
         wr(8'h4C, 8'h10 << n, OK);
         cyc(3);
         `CHK(port0_irq_en, 8'h03 << (2 * n))
         `CHK(port0_irq_out, 8'h03 << (2 * n))
      end
      wr(8'h4C, 8'h00, OK);
      cyc(3);
      `CHK(port0_irq_out, 8'h00)
      port0_irq_req <= 8'h00;
      $display("irq test done");
   endtask
   task automatic t_tone;
      wr(8'h44, 8'h02, OK);
      wr(8'h48, 8'h05, OK);
      cyc(4);
      `CHK({hg_synth_run, lg_synth_run}, 2'h3)
      `CHK({gen_power_on, tone_oe}, 2'h3)
      per(1'b1, 2);
      per(1'b0, 5);
      wr(8'h44, 8'h00, OK);
      cyc(4);
      `CHK({hg_synth_run, lg_synth_run}, 2'h1)
      `CHK({gen_power_on, tone_oe}, 2'h3)
      wr(8'h48, 8'h00, OK);
      cyc(4);
      `CHK({hg_synth_run, lg_synth_run}, 2'h0)
      `CHK({gen_power_on, tone_oe}, 2'h0)
      $display("tone test done");
   endtask
   task automatic t_mel;
      int n, lo;
      wr(8'h4C, 8'h01, OK);
      cyc(4);
      `CHK({shared_melody_pin_oe, shared_melody_pin_o}, 2'h3)
      `CHK(tone_oe, 1'b0)
      wr(8'h44, 8'h03, OK);
      cyc(10);
      lo = 0;
      // Two whole periods give a phase-free low count
      for (n = 0; n < 230; n++) begin
         @(posedge aclk);
         if (shared_melody_pin_o === 1'b0) lo++;
      end
      `CHK(lo, 114)
      `CHK({hg_synth_run, tone_oe}, 2'h2)
      ffw(1'b0);
      `CHK({port_ff_rd, shared_melody_pin_o, pin_level_rd}, 3'h0)
      ffw(1'b1);
      `CHK(port_ff_rd, 1'b1)
      wr(8'h44, 8'h00, OK);
      cyc(4);
      `CHK({shared_melody_pin_oe, shared_melody_pin_o}, 2'h3)
      `CHK(pin_level_rd, 1'b1)
      wr(8'h4C, 8'h00, OK);
      ffw(1'b0);
      `CHK({shared_melody_pin_oe, shared_melody_pin_o}, 2'h2)
      `CHK(pin_level_rd, 1'b0)
      ffw(1'b1);
      `CHK({shared_melody_pin_oe, pin_level_rd}, 2'h1)
      $display("melody test done");
   endtask
   task automatic t_rst;
      wr(8'h4C, 8'hF1, OK);
      wr(8'h44, 8'h03, OK);
      aresetn <= 1'b0;
      cyc(2);
      aresetn <= 1'b1;
      rd(8'h4C, 8'h00, OK);
      `CHK({hg_synth_run, gen_power_on}, 2'h0)
      `CHK({tone_oe, port_ff_rd}, 2'h1)
      $display("reset test done");
   endtask
   initial begin
      cyc(10);
      aresetn <= 1'b1;
      t_regs();
      t_irq();
      t_tone();
      t_mel();
      t_rst();
      conclude();
   end
endmodule
`default_nettype wire

// [tmc_tone_div.v]
// Programmable divider producing one tone's square
// wave and a once-per-period tick for the synthesizer.
// Assumes divisor is a register in the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "tmc_regs.vh"

module tmc_tone_div #(
   parameter integer MUL   = `TMC_DIV_MUL,
   parameter integer OFS   = `TMC_DIV_OFS,
   parameter integer CNT_W = 13
) (
   input  wire             aclk,
   input  wire             aresetn,
   input  wire [7:0]       divisor,
   output reg              run_q,
   output reg              wave_q,
   output reg              tick_q
);

   reg  [CNT_W-1:0] cnt_q;
   reg  [7:0]       div_seen_q;
   wire [31:0]      period_full;
   wire [CNT_W-1:0] period;
   wire [CNT_W-1:0] half;
   wire             restart;

   // Worst case 23 * 257 fits in 13 bits
   assign period_full = MUL * ({24'h000000, divisor} + OFS);
   assign period      = period_full[CNT_W-1:0];
   assign half    = {1'b0, period[CNT_W-1:1]};
   assign restart = (divisor != div_seen_q);

   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q      <= {CNT_W{1'b0}};
         div_seen_q <= `TMC_DIV_RESET;
         run_q      <= 1'b0;
         wave_q     <= 1'b0;
         tick_q     <= 1'b0;
      end else begin
         div_seen_q <= divisor;
         run_q      <= (divisor != 8'h00);
         tick_q     <= 1'b0;
         if (divisor == 8'h00 || restart) begin
            // New value starts a fresh period, no runt
            cnt_q  <= {CNT_W{1'b0}};
            wave_q <= 1'b0;
         end else if (cnt_q == period - 1'b1) begin
            cnt_q  <= {CNT_W{1'b0}};
            tick_q <= 1'b1;
            wave_q <= 1'b1;
         end else begin
            cnt_q  <= cnt_q + 1'b1;
            // Odd periods give the slightly long high half
            wave_q <= (cnt_q + 1'b1 < half + period[0]);
         end
      end
   end

endmodule
`default_nettype wire

// [tmc_top.v]
// Tone and melody control: divisor and control
// registers over AXI4-Lite, tone enable, melody pin
// and port 0 pair interrupt gating.
// Assumes aclk is the oscillator feeding the divider
// and all pin inputs are synchronous to aclk.
`timescale 1ns/100ps
`default_nettype none
`include "tmc_regs.vh"

module tmc_top #(
   parameter integer ADDR_W = 8
) (
   input  wire              aclk,
   input  wire              aresetn,
   // AXI4-Lite slave
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire [2:0]        s_axi_awprot,
   input  wire              s_axi_awvalid,
   output reg               s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output reg               s_axi_wready,
   output reg  [1:0]        s_axi_bresp,
   output reg               s_axi_bvalid,
   input  wire              s_axi_bready,
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire [2:0]        s_axi_arprot,
   input  wire              s_axi_arvalid,
   output reg               s_axi_arready,
   output reg  [31:0]       s_axi_rdata,
   output reg  [1:0]        s_axi_rresp,
   output reg               s_axi_rvalid,
   input  wire              s_axi_rready,
   // Port instructions on the shared line
   input  wire              port_ff_wr,
   input  wire              port_ff_wdata,
   output reg               port_ff_rd,
   output reg               pin_level_rd,
   // Shared melody pin
   input  wire              shared_melody_pin_i,
   output reg               shared_melody_pin_o,
   output reg               shared_melody_pin_oe,
   // Tone path towards the sine synthesizers
   output reg               tone_oe,
   output reg               gen_power_on,
   output reg               hg_synth_run,
   output reg               lg_synth_run,
   output reg               hg_synth_tick,
   output reg               lg_synth_tick,
   // Port 0 wake-up interrupts
   input  wire [7:0]        port0_irq_req,
   output reg  [7:0]        port0_irq_en,
   output reg  [7:0]        port0_irq_out
);

   // Registers
   reg  [7:0]        high_group_divisor_q;
   reg  [7:0]        low_group_divisor_q;
   reg  [7:0]        melody_port_irq_control_q;
   reg               port_ff_q;

   // Write channel state
   reg               aw_got_q;
   reg               w_got_q;
   reg  [ADDR_W-1:0] awaddr_q;
   reg  [31:0]       wdata_q;
   reg  [3:0]        wstrb_q;

   // Divider outputs
   wire              hg_run;
   wire              hg_wave;
   wire              hg_tick;
   wire              lg_run;
   wire              lg_tick;

   wire              melody_select_bit;
   wire [3:0]        pair_en;
   wire              wr_go;
   wire [5:0]        wr_idx;
   wire [5:0]        rd_idx;
   reg  [7:0]        rd_byte;
   reg               rd_hit;
   reg               wr_hit;
   wire              melody_d;
   wire              pin_oe_d;

   assign melody_select_bit =
      melody_port_irq_control_q[`TMC_CTL_MEL_BIT];
   assign pair_en =
      melody_port_irq_control_q[`TMC_CTL_EN_MSB:`TMC_CTL_EN_LSB];

   assign wr_go  = aw_got_q & w_got_q & ~s_axi_bvalid;
   assign wr_idx = awaddr_q[7:2];
   assign rd_idx = s_axi_araddr[7:2];

   // Read decode; divisors are write-only and read zero
   always @* begin
      rd_byte = 8'h00;
      rd_hit  = 1'b0;
      if (s_axi_araddr[1:0] == 2'b00) begin
         case (rd_idx)
            `TMC_IDX_HGD: begin
               rd_hit = 1'b1;
            end
            `TMC_IDX_LGD: begin
               rd_hit = 1'b1;
            end
            `TMC_IDX_CTL: begin
               rd_hit  = 1'b1;
               rd_byte = melody_port_irq_control_q;
            end
            default: begin
               rd_hit = 1'b0;
            end
         endcase
      end
   end

   // Write decode
   always @* begin
      wr_hit = 1'b0;
      if (awaddr_q[1:0] == 2'b00) begin
         case (wr_idx)
            `TMC_IDX_HGD: begin
               wr_hit = 1'b1;
            end
            `TMC_IDX_LGD: begin
               wr_hit = 1'b1;
            end
            `TMC_IDX_CTL: begin
               wr_hit = 1'b1;
            end
            default: begin
               wr_hit = 1'b0;
            end
         endcase
      end
   end

   // AXI write path and register updates
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready             <= 1'b1;
         s_axi_wready              <= 1'b1;
         s_axi_bvalid              <= 1'b0;
         s_axi_bresp               <= `TMC_RESP_OKAY;
         aw_got_q                  <= 1'b0;
         w_got_q                   <= 1'b0;
         awaddr_q                  <= {ADDR_W{1'b0}};
         wdata_q                   <= 32'h00000000;
         wstrb_q                   <= 4'h0;
         high_group_divisor_q      <= `TMC_DIV_RESET;
         low_group_divisor_q       <= `TMC_DIV_RESET;
         melody_port_irq_control_q <= `TMC_CTL_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q      <= 1'b1;
            awaddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q      <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `TMC_RESP_OKAY
                                   : `TMC_RESP_SLVERR;
            // Only byte lane 0 carries register data
            if (wr_hit && wstrb_q[0]) begin
               case (wr_idx)
                  `TMC_IDX_HGD: begin
                     high_group_divisor_q <= wdata_q[7:0];
                  end
                  `TMC_IDX_LGD: begin
                     low_group_divisor_q <= wdata_q[7:0];
                  end
                  `TMC_IDX_CTL: begin
                     melody_port_irq_control_q <=
                        wdata_q[7:0] & `TMC_CTL_WMASK;
                  end
                  default: begin
                     high_group_divisor_q <= high_group_divisor_q;
                  end
               endcase
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // AXI read path
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `TMC_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_byte};
            s_axi_rresp   <= rd_hit ? `TMC_RESP_OKAY
                                    : `TMC_RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Tone dividers, one per group
   tmc_tone_div u_hg_div (
      .aclk    (aclk),
      .aresetn (aresetn),
      .divisor (high_group_divisor_q),
      .run_q   (hg_run),
      .wave_q  (hg_wave),
      .tick_q  (hg_tick)
   );

   tmc_tone_div u_lg_div (
      .aclk    (aclk),
      .aresetn (aresetn),
      .divisor (low_group_divisor_q),
      .run_q   (lg_run),
      .wave_q  (),
      .tick_q  (lg_tick)
   );

   // Melody wave: high divisor only, steady high at zero
   assign melody_d = hg_run ? hg_wave : 1'b1;

   // Quasi-bidirectional line: strong low, weak high
   // is left to the pad, so only a low is driven here.
   // In melody mode the wave is driven both ways; a low
   // port flip-flop wins, which is why software keeps
   // it set while the melody plays.
   assign pin_oe_d = melody_select_bit | ~port_ff_q;

   // Port flip-flop and pin outputs
   always @(posedge aclk) begin
      if (!aresetn) begin
         port_ff_q            <= `TMC_PORT_RESET;
         port_ff_rd           <= `TMC_PORT_RESET;
         pin_level_rd         <= 1'b1;
         shared_melody_pin_o  <= 1'b0;
         shared_melody_pin_oe <= 1'b0;
      end else begin
         if (port_ff_wr) begin
            port_ff_q <= port_ff_wdata;
         end
         port_ff_rd   <= port_ff_q;
         pin_level_rd <= shared_melody_pin_i;
         shared_melody_pin_oe <= pin_oe_d;
         if (melody_select_bit) begin
            shared_melody_pin_o <= melody_d & port_ff_q;
         end else begin
            shared_melody_pin_o <= 1'b0;
         end
      end
   end

   // Tone enable, synth controls and power
   always @(posedge aclk) begin
      if (!aresetn) begin
         tone_oe       <= 1'b0;
         gen_power_on  <= 1'b0;
         hg_synth_run  <= 1'b0;
         lg_synth_run  <= 1'b0;
         hg_synth_tick <= 1'b0;
         lg_synth_tick <= 1'b0;
      end else begin
         // Tri-state when idle or in melody mode
         tone_oe <= ~melody_select_bit & (hg_run | lg_run);
         gen_power_on  <= hg_run | lg_run;
         hg_synth_run  <= hg_run;
         lg_synth_run  <= lg_run;
         hg_synth_tick <= hg_tick;
         lg_synth_tick <= lg_tick;
      end
   end

   // Port 0 interrupt enables, one pair per bit
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_p0
         always @(posedge aclk) begin
            if (!aresetn) begin
               port0_irq_en[gi]  <= 1'b0;
               port0_irq_out[gi] <= 1'b0;
            end else begin
               port0_irq_en[gi]  <= pair_en[gi/2];
               port0_irq_out[gi] <=
                  port0_irq_req[gi] & pair_en[gi/2];
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire
